// [hdl/cmp_irq_pkg.sv]
// constants for the timer compare stage and its shared interrupt flag register
// Operation
// - channel 0 compare value, read/write, resets zero
// - channel 1 compare value, read/write, resets zero
// - control bit 2 enables channel 1 compare
// - control bit 6 is channel interrupt mask
// - action 000 set, 001 clear, 010 toggle
// - 011 set on up-match, clear on down-match in up/down mode, else clear at zero
// - 100 clear on up-match, set on down-match in up/down mode, else set at zero
// - 101/110 use channel 0 value; 111 unused
// - second timer flags at bits 5..3
// - first timer flags at bits 2..0
// - flags cleared by writing 0, ignore 1
// - bit 6 is wide timer wrap mask
// - actions work in all counter modes
package cmp_irq_pkg;
    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_FLAGS = 8'hD8;
    localparam logic [7:0] IDX_CC0 = 8'hED;
    localparam logic [7:0] IDX_CTL1 = 8'hEE;
    localparam logic [7:0] IDX_CC1 = 8'hEF;
    localparam logic [7:0] IDX_STAT = 8'hF0;
    localparam logic [7:0] IDX_MASK = 8'hF1;
    // control field positions
    localparam int CTL_IM = 6;
    localparam int CTL_ACT_LO = 3;
    localparam int CTL_EN = 2;
    localparam int FLG_WIDE_IM = 6;
    // reset values
    localparam logic [7:0] RST_CC = 8'h00;
    localparam logic RST_IM = 1'b1;
    localparam logic [2:0] RST_ACT = 3'h0;
    localparam logic RST_EN = 1'b0;
    localparam logic [1:0] RST_RSV = 2'h0;
    localparam logic RST_WIDE_IM = 1'b1;
    localparam logic [5:0] RST_PEND = 6'h00;
    localparam logic [2:0] RST_STAT = 3'h0;
    localparam logic [2:0] RST_MASK = 3'h0;
    // output action codes
    localparam logic [2:0] ACT_SET = 3'h0;
    localparam logic [2:0] ACT_CLR = 3'h1;
    localparam logic [2:0] ACT_TGL = 3'h2;
    localparam logic [2:0] ACT_SET_UP = 3'h3;
    localparam logic [2:0] ACT_CLR_UP = 3'h4;
    localparam logic [2:0] ACT_SET_TOP = 3'h5;
    localparam logic [2:0] ACT_CLR_TOP = 3'h6;
    // counter mode with up/down counting
    localparam logic [1:0] MODE_UPDOWN = 2'h3;
    // avalon response codes
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
endpackage

// [hdl/compare_output_unit.sv]
// compare output pin action logic for one channel
`timescale 1ns/10ps
`default_nettype none
module compare_output_unit (
    // clock and synchronised reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // counter view
    input wire logic tick_i,
    input wire logic [7:0] cnt_i,
    input wire logic updown_i,
    input wire logic down_i,
    // channel setup
    input wire logic enable_i,
    input wire logic [2:0] action_i,
    input wire logic [7:0] cmp_val_i,
    input wire logic [7:0] top_val_i,
    // pin level
    output logic out_o
);
    typedef struct packed {
        logic pin;
    } out_state_t;

    out_state_t s_reg;
    out_state_t s_next;
    logic match;
    logic at_zero;
    logic at_top;
    logic down_match;

    assign match = cnt_i == cmp_val_i;
    assign at_zero = cnt_i == 8'h00;
    assign at_top = cnt_i == top_val_i;
    assign down_match = match && updown_i && down_i;

    always_comb begin
        s_next = s_reg;
        if (tick_i && enable_i) begin
            case (action_i)
                cmp_irq_pkg::ACT_SET: if (match) s_next.pin = 1'b1;
                cmp_irq_pkg::ACT_CLR: if (match) s_next.pin = 1'b0;
                cmp_irq_pkg::ACT_TGL: if (match) s_next.pin = ~s_reg.pin;
                cmp_irq_pkg::ACT_SET_UP: begin
                    if (down_match) s_next.pin = 1'b0;
                    else if (match) s_next.pin = 1'b1;
                    else if (at_zero && !updown_i) s_next.pin = 1'b0;
                end
                cmp_irq_pkg::ACT_CLR_UP: begin
                    if (down_match) s_next.pin = 1'b1;
                    else if (match) s_next.pin = 1'b0;
                    else if (at_zero && !updown_i) s_next.pin = 1'b1;
                end
                // match wins when both values coincide
                cmp_irq_pkg::ACT_SET_TOP: begin
                    if (match) s_next.pin = 1'b1;
                    else if (at_top) s_next.pin = 1'b0;
                end
                cmp_irq_pkg::ACT_CLR_TOP: begin
                    if (match) s_next.pin = 1'b0;
                    else if (at_top) s_next.pin = 1'b1;
                end
                default: s_next = s_reg;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign out_o = s_reg.pin;

    pin_toggle_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tick_i && enable_i && match && action_i == cmp_irq_pkg::ACT_TGL |=> out_o != $past(out_o))
        else $error("toggle action did not invert the pin");
    pin_downmatch_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tick_i && enable_i && down_match && action_i == cmp_irq_pkg::ACT_SET_UP |=> !out_o)
        else $error("down match did not clear the pin");
    pin_top_clear_a: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
        tick_i && enable_i && at_top && !match && action_i == cmp_irq_pkg::ACT_SET_TOP |=> !out_o)
        else $error("reaching channel 0 value did not clear the pin");
endmodule
`default_nettype wire

// [hdl/timer_compare_channels_irq_flags.sv]
// timer compare registers, channel 1 output, shared pending flags, avalon slave
//
// Register access over Avalon-MM was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module timer_compare_channels_irq_flags (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // avalon-mm slave
    input wire logic [9:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [3:0] byteenable_i,
    output logic [31:0] readdata_o,
    output logic [1:0] response_o,
    output logic waitrequest_o,
    // second timer counter, same clock
    input wire logic [7:0] cnt_i,
    input wire logic tick_i,
    input wire logic down_i,
    input wire logic [1:0] mode_i,
    input wire logic wrap_i,
    input wire logic ch0_enable_i,
    input wire logic ch0_irq_enable_i,
    input wire logic wrap_irq_enable_i,
    // first timer events, same clock
    input wire logic ft_ch0_i,
    input wire logic ft_ch1_i,
    input wire logic ft_wrap_i,
    // outputs
    output logic compare1_out_o,
    output logic timer_irq_o,
    output logic wide_wrap_irq_enable_o,
    output logic irq_o
);
    typedef struct packed {
        logic [7:0] cc0;
        logic [7:0] cc1;
        logic ch1_im;
        logic [2:0] ch1_act;
        logic ch1_en;
        logic [1:0] ch1_rsv;
        logic wide_im;
        logic [5:0] pend;
        logic [2:0] stat;
        logic [2:0] mask;
        logic ack;
        logic [31:0] rdata;
        logic [1:0] resp;
    } regs_t;

    regs_t s_reg;
    regs_t s_next;
    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic hit_cc0;
    logic hit_ctl1;
    logic hit_cc1;
    logic hit_flags;
    logic hit_stat;
    logic hit_mask;
    logic mapped;
    logic [7:0] rd_byte;
    logic [7:0] wd;
    logic wr_en;
    logic [5:0] ev;

    // release reset in step with the clock so all flops leave reset together
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // address decode; only aligned words of the map answer
    always_comb begin
        hit_cc0 = 1'b0;
        hit_ctl1 = 1'b0;
        hit_cc1 = 1'b0;
        hit_flags = 1'b0;
        hit_stat = 1'b0;
        hit_mask = 1'b0;
        if (address_i[1:0] != 2'h0) begin
            hit_cc0 = 1'b0;
        end else if (address_i[9:2] == cmp_irq_pkg::IDX_CC0) begin
            hit_cc0 = 1'b1;
        end else if (address_i[9:2] == cmp_irq_pkg::IDX_CTL1) begin
            hit_ctl1 = 1'b1;
        end else if (address_i[9:2] == cmp_irq_pkg::IDX_CC1) begin
            hit_cc1 = 1'b1;
        end else if (address_i[9:2] == cmp_irq_pkg::IDX_FLAGS) begin
            hit_flags = 1'b1;
        end else if (address_i[9:2] == cmp_irq_pkg::IDX_STAT) begin
            hit_stat = 1'b1;
        end else if (address_i[9:2] == cmp_irq_pkg::IDX_MASK) begin
            hit_mask = 1'b1;
        end
    end
    assign mapped = hit_cc0 | hit_ctl1 | hit_cc1 | hit_flags | hit_stat | hit_mask;

    // read mux; unused bit 7 of control and flag registers reads zero
    always_comb begin
        rd_byte = 8'h00;
        if (hit_cc0) begin
            rd_byte = s_reg.cc0;
        end else if (hit_ctl1) begin
            // bit 7 zero, reserved bits read back as written
            rd_byte = {1'b0, s_reg.ch1_im, s_reg.ch1_act, s_reg.ch1_en, s_reg.ch1_rsv};
        end else if (hit_cc1) begin
            rd_byte = s_reg.cc1;
        end else if (hit_flags) begin
            rd_byte = {1'b0, s_reg.wide_im, s_reg.pend};
        end else if (hit_stat) begin
            rd_byte = {5'h00, s_reg.stat};
        end else if (hit_mask) begin
            rd_byte = {5'h00, s_reg.mask};
        end
    end

    assign wd = writedata_i[7:0];
    // a write lands at the edge where waitrequest is low
    assign wr_en = write_i && s_reg.ack && byteenable_i[0];

    // match events, only on the cycle the counter takes a new value
    assign ev[5] = tick_i && s_reg.ch1_en && (cnt_i == s_reg.cc1);
    assign ev[4] = tick_i && ch0_enable_i && (cnt_i == s_reg.cc0);
    assign ev[3] = wrap_i;
    assign ev[2] = ft_ch1_i;
    assign ev[1] = ft_ch0_i;
    assign ev[0] = ft_wrap_i;

    always_comb begin
        s_next = s_reg;
        s_next.ack = (read_i || write_i) && !s_reg.ack;
        if (wr_en && hit_cc0) begin
            s_next.cc0 = wd;
        end
        if (wr_en && hit_cc1) begin
            s_next.cc1 = wd;
        end
        if (wr_en && hit_ctl1) begin
            s_next.ch1_im = wd[cmp_irq_pkg::CTL_IM];
            s_next.ch1_act = wd[cmp_irq_pkg::CTL_ACT_LO +: 3];
            s_next.ch1_en = wd[cmp_irq_pkg::CTL_EN];
            s_next.ch1_rsv = wd[1:0];
        end
        // a zero clears a flag, a one leaves it
        if (wr_en && hit_flags) begin
            s_next.wide_im = wd[cmp_irq_pkg::FLG_WIDE_IM];
            s_next.pend = s_reg.pend & wd[5:0];
        end
        // set wins over a clear in the same cycle
        s_next.pend = s_next.pend | ev;
        // second timer events, write one to clear, set wins
        if (wr_en && hit_stat) begin
            s_next.stat = s_reg.stat & ~wd[2:0];
        end
        s_next.stat = s_next.stat | ev[5:3];
        if (wr_en && hit_mask) begin
            s_next.mask = wd[2:0];
        end
        // read data is caught one edge ahead so it stands when waitrequest drops
        if (s_next.ack) begin
            s_next.rdata = read_i ? {24'h000000, rd_byte} : 32'h00000000;
            s_next.resp = mapped ? cmp_irq_pkg::RESP_OK : cmp_irq_pkg::RESP_ERR;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_reg.cc0 <= cmp_irq_pkg::RST_CC;
            s_reg.cc1 <= cmp_irq_pkg::RST_CC;
            s_reg.ch1_im <= cmp_irq_pkg::RST_IM;
            s_reg.ch1_act <= cmp_irq_pkg::RST_ACT;
            s_reg.ch1_en <= cmp_irq_pkg::RST_EN;
            s_reg.ch1_rsv <= cmp_irq_pkg::RST_RSV;
            s_reg.wide_im <= cmp_irq_pkg::RST_WIDE_IM;
            s_reg.pend <= cmp_irq_pkg::RST_PEND;
            s_reg.stat <= cmp_irq_pkg::RST_STAT;
            s_reg.mask <= cmp_irq_pkg::RST_MASK;
            s_reg.ack <= 1'b0;
            s_reg.rdata <= 32'h00000000;
            s_reg.resp <= cmp_irq_pkg::RESP_OK;
        end else begin
            s_reg <= s_next;
        end
    end

    compare_output_unit u_ch1_out (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n),
        .tick_i(tick_i),
        .cnt_i(cnt_i),
        .updown_i(mode_i == cmp_irq_pkg::MODE_UPDOWN),
        .down_i(down_i),
        .enable_i(s_reg.ch1_en),
        .action_i(s_reg.ch1_act),
        .cmp_val_i(s_reg.cc1),
        .top_val_i(s_reg.cc0),
        .out_o(compare1_out_o)
    );

    assign waitrequest_o = (read_i || write_i) && !s_reg.ack;
    assign readdata_o = s_reg.rdata;
    assign response_o = s_reg.resp;
    assign wide_wrap_irq_enable_o = s_reg.wide_im;
    // pending flag gated by its own mask
    assign timer_irq_o = (s_reg.pend[5] && s_reg.ch1_im) || (s_reg.pend[4] && ch0_irq_enable_i)
        || (s_reg.pend[3] && wrap_irq_enable_i);
    assign irq_o = |(s_reg.stat & s_reg.mask);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n);

    sequence bus_req_s;
        (read_i || write_i) && !s_reg.ack;
    endsequence
    sequence bus_done_s;
        !waitrequest_o;
    endsequence

    bus_wait_one_a: assert property (bus_req_s |-> waitrequest_o ##1 bus_done_s)
        else $error("slave did not answer on the second cycle");
    cc0_store_a: assert property (wr_en && hit_cc0 |=> s_reg.cc0 == $past(wd))
        else $error("channel 0 compare value not stored");
    cc1_store_a: assert property (wr_en && hit_cc1 |=> s_reg.cc1 == $past(wd))
        else $error("channel 1 compare value not stored");
    ch1_flag_cause_a: assert property ($rose(s_reg.pend[5]) |-> $past(tick_i && s_reg.ch1_en))
        else $error("channel 1 flag set without enabled match");
    ch1_flag_set_a: assert property (ev[5] |=> s_reg.pend[5] && (timer_irq_o || !s_reg.ch1_im))
        else $error("channel 1 match did not raise its flag");
    flag_zero_clear_a: assert property (wr_en && hit_flags && !wd[4] && !ev[4] |=> !s_reg.pend[4])
        else $error("writing zero did not clear the flag");
    flag_one_keep_a: assert property (wr_en && hit_flags && wd[3] && !s_reg.pend[3] && !wrap_i
        |=> !s_reg.pend[3])
        else $error("writing one changed a flag");
    first_flags_a: assert property (ft_ch0_i ##1 1'b1 |-> s_reg.pend[1] && $past(ft_ch0_i))
        else $error("first timer channel 0 flag not set");
    wrap_flag_a: assert property (wrap_i |=> s_reg.pend[3] && s_reg.stat[0])
        else $error("wrap did not set its flags");
    wide_mask_a: assert property (wr_en && hit_flags |=> wide_wrap_irq_enable_o == $past(wd[6]))
        else $error("wide timer wrap mask not stored");
    ctl_bit7_a: assert property (read_i && !waitrequest_o && hit_ctl1 |-> !readdata_o[7])
        else $error("unused control bit read as one");
    im_store_a: assert property (wr_en && hit_ctl1 ##1 1'b1 |-> s_reg.ch1_im == $past(wd[6], 1))
        else $error("channel interrupt mask not stored");
endmodule
`default_nettype wire

// [tb/ctr_model.sv]
// behavioural second-timer counter driving the compare stage
`timescale 1ns/10ps
`default_nettype none
module ctr_model (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // bench control
    input wire logic run_i,
    input wire logic [1:0] mode_i,
    input wire logic [7:0] top_i,
    // counter view
    output logic [7:0] cnt_o,
    output logic tick_o,
    output logic down_o,
    output logic wrap_o
);
    logic [7:0] cnt_next;
    logic down_next;
    assign tick_o = run_i;
    always_comb begin
        down_next = down_o;
        cnt_next = cnt_o + 8'h01;
        wrap_o = 1'b0;
        case (mode_i)
            2'h0: wrap_o = cnt_o == 8'hFF;
            2'h1: begin
                wrap_o = cnt_o == 8'h00;
                cnt_next = wrap_o ? top_i : cnt_o - 8'h01;
            end
            2'h2: begin
                wrap_o = cnt_o >= top_i;
                cnt_next = wrap_o ? 8'h00 : cnt_o + 8'h01;
            end
            default: begin
                wrap_o = down_o && cnt_o == 8'h00;
                down_next = down_o ? cnt_o != 8'h00 : cnt_o >= top_i;
                cnt_next = down_next ? cnt_o - 8'h01 : cnt_o + 8'h01;
            end
        endcase
        wrap_o = wrap_o && run_i;
    end
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_o <= 8'h00;
            down_o <= 1'b0;
        end else if (!run_i) begin
            // park at the start point so every run begins cleanly
            cnt_o <= (mode_i == 2'h1) ? top_i : 8'h00;
            down_o <= mode_i == 2'h1;
        end else begin
            cnt_o <= cnt_next;
            down_o <= down_next;
        end
    end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// self-checking bench for the compare stage and shared flag register
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [9:0] A_FL = {cmp_irq_pkg::IDX_FLAGS, 2'b00};
    localparam logic [9:0] A_C0 = {cmp_irq_pkg::IDX_CC0, 2'b00};
    localparam logic [9:0] A_CT = {cmp_irq_pkg::IDX_CTL1, 2'b00};
    localparam logic [9:0] A_C1 = {cmp_irq_pkg::IDX_CC1, 2'b00};
    localparam logic [9:0] A_ST = {cmp_irq_pkg::IDX_STAT, 2'b00};
    localparam logic [9:0] A_MK = {cmp_irq_pkg::IDX_MASK, 2'b00};
    logic mclk_i = 1'b0, rst_n_i = 1'b0, read_i = 1'b0, write_i = 1'b0, run = 1'b0;
    logic [9:0] address_i = 10'h000;
    logic [31:0] writedata_i = 32'h0, readdata_o;
    logic [3:0] byteenable_i = 4'hF;
    logic [1:0] mode_i = 2'h0, response_o;
    logic ch0_enable_i = 1'b0, ch0_irq_enable_i = 1'b0, wrap_irq_enable_i = 1'b0;
    logic ft_ch0_i = 1'b0, ft_ch1_i = 1'b0, ft_wrap_i = 1'b0;
    logic waitrequest_o, tick_i, down_i, wrap_i, compare1_out_o, timer_irq_o, wide_wrap_irq_enable_o, irq_o;
    logic [7:0] cnt_i, cc0, cc1, ctl;
    logic [5:0] pend, clr;
    logic [2:0] stat, msk, sclr;
    logic wim, pin, m0, m1, ud, chk_on = 1'b0;
    logic [15:0] seed = 16'd57078;
    int err_count = 0, compares = 0;

    timer_compare_channels_irq_flags i_timer_compare_channels_irq_flags (.mclk_i, .rst_n_i, .address_i,
        .read_i, .write_i, .writedata_i, .byteenable_i, .readdata_o, .response_o, .waitrequest_o, .cnt_i,
        .tick_i, .down_i, .mode_i, .wrap_i, .ch0_enable_i, .ch0_irq_enable_i, .wrap_irq_enable_i, .ft_ch0_i,
        .ft_ch1_i, .ft_wrap_i, .compare1_out_o, .timer_irq_o, .wide_wrap_irq_enable_o, .irq_o);
    ctr_model i_ctr_model (.mclk_i, .rst_n_i, .run_i(run), .mode_i, .top_i(cc0), .cnt_o(cnt_i),
        .tick_o(tick_i), .down_o(down_i), .wrap_o(wrap_i));

    always #5 mclk_i = ~mclk_i;

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [33:0] exp_reg(input logic [9:0] a);
        case (a)
            A_FL: return {cmp_irq_pkg::RESP_OK, 24'h0, 1'b0, wim, pend};
            A_C0: return {cmp_irq_pkg::RESP_OK, 24'h0, cc0};
            A_CT: return {cmp_irq_pkg::RESP_OK, 24'h0, ctl};
            A_C1: return {cmp_irq_pkg::RESP_OK, 24'h0, cc1};
            A_ST: return {cmp_irq_pkg::RESP_OK, 29'h0, stat};
            A_MK: return {cmp_irq_pkg::RESP_OK, 29'h0, msk};
            default: return {cmp_irq_pkg::RESP_ERR, 32'h0};
        endcase
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be,
                       output logic [31:0] rd, output logic [1:0] rs);
        logic done;
        done = 1'b0;
        address_i <= a;
        writedata_i <= {24'h0, d};
        byteenable_i <= be;
        write_i <= w;
        read_i <= !w;
        // look at waitrequest mid-cycle, where it is settled, then let the edge pass
        do begin
            @(negedge mclk_i);
            done = waitrequest_o === 1'b0;
            rd = readdata_o;
            rs = response_o;
            @(posedge mclk_i);
        end while (!done);
        write_i <= 1'b0;
        read_i <= 1'b0;
        @(posedge mclk_i);
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        logic [31:0] rd;
        logic [1:0] rs;
        bus(1'b1, a, d, 4'h1, rd, rs);
    endtask
    task automatic rchk(input logic [9:0] a);
        logic [33:0] e;
        logic [31:0] rd;
        logic [1:0] rs;
        e = exp_reg(a);
        bus(1'b0, a, 8'h00, 4'hF, rd, rs);
        chk(rd, e[31:0]);
        chk({30'h0, rs}, {30'h0, e[33:32]});
    endtask
    task automatic read_all();
        rchk(A_FL);
        rchk(A_C0);
        rchk(A_CT);
        rchk(A_C1);
        rchk(A_ST);
        rchk(A_MK);
        rchk(10'h3FC);
        rchk(A_C0 + 10'h001);
    endtask
    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // reference of the block: pin, flags, status and register writes
    // runs mid-cycle: outputs of the last edge are settled, inputs are those of the next edge
    always @(negedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            {cc0, cc1, ctl, wim, pend, stat, msk, pin} = {16'h0, 8'h40, 1'b1, 13'h0};
        end else begin
            if (chk_on) begin
                chk({31'h0, compare1_out_o}, {31'h0, pin});
                chk({31'h0, timer_irq_o}, {31'h0, (pend[5] & ctl[6]) | (pend[4] & ch0_irq_enable_i) |
                    (pend[3] & wrap_irq_enable_i)});
                chk({31'h0, irq_o}, {31'h0, |(stat & msk)});
                chk({31'h0, wide_wrap_irq_enable_o}, {31'h0, wim});
            end
            ud = mode_i == cmp_irq_pkg::MODE_UPDOWN;
            m1 = tick_i && ctl[2] && cnt_i == cc1;
            m0 = tick_i && ch0_enable_i && cnt_i == cc0;
            if (tick_i && ctl[2]) begin
                case (ctl[5:3])
                    3'h0: pin = m1 | pin;
                    3'h1: pin = !m1 & pin;
                    3'h2: pin = m1 ^ pin;
                    3'h3: pin = (m1 && !(ud && down_i)) ? 1'b1 : ((ud ? m1 : cnt_i == 8'h00) ? 1'b0 : pin);
                    3'h4: pin = (m1 && !(ud && down_i)) ? 1'b0 : ((ud ? m1 : cnt_i == 8'h00) ? 1'b1 : pin);
                    3'h5: pin = m1 ? 1'b1 : ((cnt_i == cc0) ? 1'b0 : pin);
                    3'h6: pin = m1 ? 1'b0 : ((cnt_i == cc0) ? 1'b1 : pin);
                    default: ;
                endcase
            end
            clr = 6'h3F;
            sclr = 3'h0;
            if (write_i && !waitrequest_o && byteenable_i[0]) begin
                case (address_i)
                    A_FL: {wim, clr} = writedata_i[6:0];
                    A_C0: cc0 = writedata_i[7:0];
                    A_C1: cc1 = writedata_i[7:0];
                    A_CT: ctl = {1'b0, writedata_i[6:0]};
                    A_ST: sclr = writedata_i[2:0];
                    A_MK: msk = writedata_i[2:0];
                    default: ;
                endcase
            end
            pend = (pend & clr) | {m1, m0, wrap_i, ft_ch1_i, ft_ch0_i, ft_wrap_i};
            stat = (stat & ~sclr) | {m1, m0, wrap_i};
        end
    end

    initial begin
        logic [31:0] rd;
        logic [1:0] rs;
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        read_all();
        $display("reset values done");
        chk_on = 1'b1;
        for (int r = 0; r < 16; r++) begin
            seed = lfsr_next(seed);
            wr(A_C0, 8'h80 | {1'b0, seed[6:0]});
            wr(A_C1, 8'h01 + ({1'b0, seed[14:8]} % (cc0 - 8'h01)));
            wr(A_CT, {1'b0, seed[15], 3'(r), r != 9, 2'b00});
            seed = lfsr_next(seed);
            wr(A_FL, seed[7:0]);
            wr(A_MK, {5'h0, seed[10:8]});
            mode_i <= 2'(r + r / 8);
            {ch0_enable_i, ch0_irq_enable_i, wrap_irq_enable_i} <= seed[13:11];
            run <= 1'b1;
            repeat (520) begin
                @(posedge mclk_i);
                seed = lfsr_next(seed);
                ft_ch0_i <= seed[3:0] == 4'h0;
                ft_ch1_i <= seed[7:4] == 4'h1;
                ft_wrap_i <= seed[11:8] == 4'h2;
            end
            {run, ft_ch0_i, ft_ch1_i, ft_wrap_i} <= 4'h0;
            repeat (2) @(posedge mclk_i);
            read_all();
            wr(A_ST, {5'h0, seed[5:3]});
            $display("round %0d done, action %0d mode %0d", r, r % 8, mode_i);
        end
        bus(1'b1, A_C0, 8'h5A, 4'h0, rd, rs);
        bus(1'b1, 10'h3FC, 8'hFF, 4'h1, rd, rs);
        read_all();
        $display("refused writes done");
        finish_test();
    end

    initial begin
        #400000;
        err_count++;
        finish_test();
    end
endmodule
`default_nettype wire
